/* src/pfh_pkg.sv */
package pfh_pkg;
    // Software-visible register offsets (byte addresses, one word each)
    localparam logic [11:0] REG_CMD     = 12'h000;
    localparam logic [11:0] REG_ADDR    = 12'h004;
    localparam logic [11:0] REG_DATA    = 12'h008;
    localparam logic [11:0] REG_STATUS  = 12'h00C;
    localparam logic [11:0] REG_RDATA   = 12'h010;
    localparam logic [11:0] REG_TIMING  = 12'h014;
    localparam logic [11:0] REG_POLLCNT = 12'h018;

    // Command codes written to REG_CMD
    localparam logic [3:0] OP_READ    = 4'h1;
    localparam logic [3:0] OP_RESET   = 4'h2;
    localparam logic [3:0] OP_IDENT   = 4'h3;
    localparam logic [3:0] OP_PROGRAM = 4'h4;
    localparam logic [3:0] OP_CHIPER  = 4'h5;
    localparam logic [3:0] OP_SECTER  = 4'h6;
    localparam logic [3:0] OP_SUSPEND = 4'h7;
    localparam logic [3:0] OP_RESUME  = 4'h8;
    localparam logic [3:0] OP_WRITE   = 4'h9;

    // Flash bus addresses and data of the command sequences
    localparam logic [16:0] FA_UNLOCK1 = 17'h00555;
    localparam logic [16:0] FA_UNLOCK2 = 17'h002AA;
    localparam logic [7:0]  FD_UNLOCK1 = 8'hAA;
    localparam logic [7:0]  FD_UNLOCK2 = 8'h55;
    localparam logic [7:0]  FD_RESET   = 8'hF0;
    localparam logic [7:0]  FD_IDENT   = 8'h90;
    localparam logic [7:0]  FD_PROGRAM = 8'hA0;
    localparam logic [7:0]  FD_ERASE   = 8'h80;
    localparam logic [7:0]  FD_CHIP    = 8'h10;
    localparam logic [7:0]  FD_SECTOR  = 8'h30;
    localparam logic [7:0]  FD_SUSPEND = 8'hB0;
    localparam logic [7:0]  FD_RESUME  = 8'h30;

    // Status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;

    // Pin phase timing in clock cycles (default 10 cycles, 80 ns per phase)
    localparam logic [7:0] PHASE_CYC_RST = 8'h0A;
    localparam logic [15:0] POLL_MAX_RST = 16'hFFFF;

    // One bus step toward the flash
    typedef struct packed {
        logic        wr;
        logic [16:0] addr;
        logic [7:0]  data;
    } pfh_step_t;

    // Flash pins driven by the controller
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [16:0] addr;
        logic [7:0]  dq_out;
        logic        dq_oe_n;
    } pfh_pins_t;
endpackage : pfh_pkg

/* src/pfh_cycle.sv */
`timescale 1ns/1ps
// Performs one flash bus cycle (read or write) with programmable phase length
module pfh_cycle (
    input  wire logic              clk_i,      // Clock
    input  wire logic              reset_n_i,  // Async reset, active low
    input  wire logic              start_i,    // Begin a cycle
    input  wire pfh_pkg::pfh_step_t step_i,    // Cycle description
    input  wire logic [7:0]        phase_i,    // Cycles per phase
    input  wire logic [7:0]        dq_i,       // Synchronised data pins
    output pfh_pkg::pfh_pins_t     pins_o,     // Registered pin drive
    output logic [7:0]             rdata_o,    // Captured read byte
    output logic                   done_o      // One-cycle completion pulse
);
    import pfh_pkg::*;

    typedef enum logic [1:0] {
        CY_IDLE  = 2'b00,
        CY_SETUP = 2'b01,
        CY_ACT   = 2'b10,
        CY_HOLD  = 2'b11
    } pfh_cy_t;

    pfh_cy_t    state,  next_state;
    logic [7:0] cnt,    next_cnt;
    pfh_step_t  cur,    next_cur;
    pfh_pins_t  next_pins;
    logic [7:0] next_rdata;
    logic       next_done;

    // Setup: address stable, strobes high. Active: strobe low. Hold: release.
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_cur   = cur;
        next_pins  = pins_o;
        next_rdata = rdata_o;
        next_done  = 1'b0;
        unique case (state)
            CY_IDLE: begin
                if (start_i) begin
                    next_cur            = step_i;
                    next_pins.addr      = step_i.addr;
                    next_pins.dq_out    = step_i.data;
                    next_pins.oe_n      = 1'b1;
                    next_pins.we_n      = 1'b1;
                    next_pins.ce_n      = 1'b1;
                    next_pins.dq_oe_n   = ~step_i.wr;
                    next_cnt            = phase_i;
                    next_state          = CY_SETUP;
                end
            end
            CY_SETUP: begin
                if (cnt <= 8'h01) begin
                    next_pins.ce_n = 1'b0;
                    next_pins.we_n = ~cur.wr;
                    next_pins.oe_n = cur.wr;
                    next_cnt       = phase_i;
                    next_state     = CY_ACT;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            CY_ACT: begin
                if (cnt <= 8'h01) begin
                    // Sample before strobes rise; dq_i lags by the sync stages
                    if (!cur.wr) begin
                        next_rdata = dq_i;
                    end
                    next_pins.ce_n = 1'b1;
                    next_pins.we_n = 1'b1;
                    next_pins.oe_n = 1'b1;
                    next_cnt       = phase_i;
                    next_state     = CY_HOLD;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            CY_HOLD: begin
                if (cnt <= 8'h01) begin
                    next_pins.dq_oe_n = 1'b1;
                    next_done         = 1'b1;
                    next_state        = CY_IDLE;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state   <= CY_IDLE;
            cnt     <= 8'h00;
            cur     <= '0;
            pins_o  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 17'h00000,
                         dq_out: 8'h00, dq_oe_n: 1'b1};
            rdata_o <= 8'h00;
            done_o  <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            cur     <= next_cur;
            pins_o  <= next_pins;
            rdata_o <= next_rdata;
            done_o  <= next_done;
        end
    end
endmodule : pfh_cycle

/* src/pfh_top.sv */
`timescale 1ns/1ps
// What this block does
// - Write: CE, WE low, OE high
// - Completion detected by polling status bits
// - Unlock AA at 555, 55 at 2AA
// - F0 anywhere resets to array read
// - 90 at 555 enters identification mode
// - Program: unlock, A0, byte at target
// - Erase: unlock, 80, unlock, 10 or 30
// - B0 suspends, 30 resumes sector erase
// - Host writes reset to leave identification
module pfh_top (
    input  wire logic        clk_i,      // Clock, 125 MHz
    input  wire logic        reset_n_i,  // Async reset, active low
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB enable
    input  wire logic        pwrite,     // APB direction
    input  wire logic [11:0] paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic [31:0]      prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error
    output logic             ce_n_o,     // Flash chip select, low active
    output logic             oe_n_o,     // Flash output enable, low active
    output logic             we_n_o,     // Flash write strobe, low active
    output logic [16:0]      addr_o,     // Flash address
    output logic [7:0]       dq_o,       // Flash data out
    output logic             dq_oe_n_o,  // Flash data drive enable, low = driving
    input  wire logic [7:0]  dq_i        // Flash data in (asynchronous)
);
    import pfh_pkg::*;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_ISSUE = 3'b001,
        SQ_WAIT = 3'b010,
        SQ_POLL = 3'b011,
        SQ_PWAIT = 3'b100
    } pfh_sq_t;

    // Sequencer state
    pfh_sq_t     state,    next_state;
    logic [2:0]  idx,      next_idx;
    logic [2:0]  nsteps,   next_nsteps;
    logic [3:0]  op,       next_op;
    logic [16:0] faddr,    next_faddr;
    logic [7:0]  fdata,    next_fdata;
    logic [7:0]  phase,    next_phase;
    logic [15:0] pollmax,  next_pollmax;
    logic [15:0] pollcnt,  next_pollcnt;
    logic [7:0]  prev_rd,  next_prev_rd;
    logic        busy,     next_busy;
    logic        done,     next_done;
    logic        fail,     next_fail;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        first_poll, next_first_poll;

    // Cycle engine wiring
    logic        cy_start;
    pfh_step_t   cy_step;
    pfh_pins_t   cy_pins;
    logic [7:0]  cy_rdata;
    logic        cy_done;
    logic [7:0]  dq_meta, dq_sync;

    // Two-stage synchroniser on the asynchronous data pins
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dq_meta <= 8'h00;
            dq_sync <= 8'h00;
        end else begin
            dq_meta <= dq_i;
            dq_sync <= dq_meta;
        end
    end

    pfh_cycle u_cycle (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .start_i   (cy_start),
        .step_i    (cy_step),
        .phase_i   (phase),
        .dq_i      (dq_sync),
        .pins_o    (cy_pins),
        .rdata_o   (cy_rdata),
        .done_o    (cy_done)
    );

    // Pins come straight from the cycle engine's flops
    assign ce_n_o    = cy_pins.ce_n;
    assign oe_n_o    = cy_pins.oe_n;
    assign we_n_o    = cy_pins.we_n;
    assign addr_o    = cy_pins.addr;
    assign dq_o      = cy_pins.dq_out;
    assign dq_oe_n_o = cy_pins.dq_oe_n;

    // Step table: bus cycle for op at idx; every poll is a read at faddr
    always_comb begin
        cy_step = '{wr: 1'b1, addr: faddr, data: fdata};
        unique case ((state == SQ_POLL) ? OP_READ : op)
            OP_RESET:   cy_step.data = FD_RESET;
            OP_SUSPEND: cy_step.data = FD_SUSPEND;
            OP_RESUME:  cy_step.data = FD_RESUME;
            OP_READ:    cy_step.wr   = 1'b0;
            OP_WRITE:   cy_step.wr   = 1'b1;
            default: begin
                // unlock prefix, code at 2, erase unlocks at 3 and 4
                if (idx == 3'd0 || (nsteps == 3'd6 && idx == 3'd3)) begin
                    cy_step.addr = FA_UNLOCK1;
                    cy_step.data = FD_UNLOCK1;
                end else if (idx == 3'd1 || (nsteps == 3'd6 && idx == 3'd4)) begin
                    cy_step.addr = FA_UNLOCK2;
                    cy_step.data = FD_UNLOCK2;
                end else if (idx == 3'd2) begin
                    cy_step.addr = FA_UNLOCK1;
                    cy_step.data = (op == OP_IDENT)   ? FD_IDENT :
                                   (op == OP_PROGRAM) ? FD_PROGRAM : FD_ERASE;
                end else if (op == OP_PROGRAM) begin
                    cy_step.addr = faddr;
                    cy_step.data = fdata;
                end else if (op == OP_CHIPER) begin
                    cy_step.addr = FA_UNLOCK1;
                    cy_step.data = FD_CHIP;
                end else begin
                    // sector chosen by address bits 16..12
                    cy_step.addr = {faddr[16:12], 12'h000};
                    cy_step.data = FD_SECTOR;
                end
            end
        endcase
    end

    // Sequencer and APB slave. A read follows a program or erase to watch
    // the toggle bit; polling is bounded so a stuck flash is reported.
    always_comb begin
        next_state      = state;
        next_idx        = idx;
        next_nsteps     = nsteps;
        next_op         = op;
        next_faddr      = faddr;
        next_fdata      = fdata;
        next_phase      = phase;
        next_pollmax    = pollmax;
        next_pollcnt    = pollcnt;
        next_prev_rd    = prev_rd;
        next_busy       = busy;
        next_done       = done;
        next_fail       = fail;
        next_first_poll = first_poll;
        next_prdata     = prdata;
        next_pready     = 1'b0;
        cy_start        = 1'b0;

        unique case (state)
            SQ_IDLE: ;
            SQ_ISSUE: begin
                cy_start   = 1'b1;
                next_state = SQ_WAIT;
            end
            SQ_WAIT: begin
                if (cy_done) begin
                    if (idx + 3'd1 < nsteps) begin
                        next_idx   = idx + 3'd1;
                        next_state = SQ_ISSUE;
                    end else if (op == OP_PROGRAM || op == OP_CHIPER ||
                                 op == OP_SECTER) begin
                        // flash times itself; sequencer polls toggle bit
                        next_first_poll = 1'b1;
                        next_pollcnt    = 16'h0000;
                        next_state      = SQ_POLL;
                    end else begin
                        next_busy  = 1'b0;
                        next_done  = 1'b1;
                        next_state = SQ_IDLE;
                    end
                end
            end
            SQ_POLL: begin
                cy_start   = 1'b1;
                next_state = SQ_PWAIT;
            end
            SQ_PWAIT: begin
                if (cy_done) begin
                    next_prev_rd    = cy_rdata;
                    next_first_poll = 1'b0;
                    if (!first_poll && cy_rdata[6] == prev_rd[6]) begin
                        // Toggle bit stopped: operation finished
                        next_busy  = 1'b0;
                        next_done  = 1'b1;
                        next_state = SQ_IDLE;
                    end else if (pollcnt == pollmax) begin
                        // Poll limit reached: timed out or stuck flash
                        next_busy  = 1'b0;
                        next_fail  = 1'b1;
                        next_state = SQ_IDLE;
                    end else begin
                        next_pollcnt = pollcnt + 16'h0001;
                        next_state   = SQ_POLL;
                    end
                end
            end
            default: next_state = SQ_IDLE;
        endcase

        // APB access phase; answers one cycle after the access starts
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            if (pwrite) begin
                unique case (paddr)
                    REG_ADDR:   next_faddr   = pwdata[16:0];
                    REG_DATA:   next_fdata   = pwdata[7:0];
                    REG_TIMING: next_phase   = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
                    REG_POLLCNT: next_pollmax = pwdata[15:0];
                    REG_STATUS: begin
                        // Write one to clear; a set in the same cycle wins
                        if (pwdata[ST_DONE]) next_done = next_done & ~done;
                        if (pwdata[ST_FAIL]) next_fail = next_fail & ~fail;
                    end
                    REG_CMD: begin
                        // Commands while busy are ignored
                        if (!busy && pwdata[3:0] >= OP_READ && pwdata[3:0] <= OP_WRITE) begin
                            next_op     = pwdata[3:0];
                            next_idx    = 3'd0;
                            next_busy   = 1'b1;
                            next_done   = 1'b0;
                            next_fail   = 1'b0;
                            next_state  = SQ_ISSUE;
                            unique case (pwdata[3:0])
                                OP_IDENT:   next_nsteps = 3'd3;
                                OP_PROGRAM: next_nsteps = 3'd4;
                                OP_CHIPER, OP_SECTER: next_nsteps = 3'd6;
                                default:              next_nsteps = 3'd1;
                            endcase
                        end
                    end
                    default: ;
                endcase
            end else begin
                unique case (paddr)
                    REG_CMD:     next_prdata = {28'h0, op};
                    REG_ADDR:    next_prdata = {15'h0, faddr};
                    REG_DATA:    next_prdata = {24'h0, fdata};
                    REG_STATUS:  next_prdata = {29'h0, fail, done, busy};
                    REG_RDATA:   next_prdata = {24'h0, cy_rdata};
                    REG_TIMING:  next_prdata = {24'h0, phase};
                    REG_POLLCNT: next_prdata = {16'h0, pollmax};
                    default:     next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Register stage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state      <= SQ_IDLE;
            idx        <= 3'd0;
            nsteps     <= 3'd1;
            op         <= OP_READ;
            faddr      <= 17'h00000;
            fdata      <= 8'h00;
            phase      <= PHASE_CYC_RST;
            pollmax    <= POLL_MAX_RST;
            pollcnt    <= 16'h0000;
            prev_rd    <= 8'h00;
            busy       <= 1'b0;
            done       <= 1'b0;
            fail       <= 1'b0;
            first_poll <= 1'b0;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
        end else begin
            state      <= next_state;
            idx        <= next_idx;
            nsteps     <= next_nsteps;
            op         <= next_op;
            faddr      <= next_faddr;
            fdata      <= next_fdata;
            phase      <= next_phase;
            pollmax    <= next_pollmax;
            pollcnt    <= next_pollcnt;
            prev_rd    <= next_prev_rd;
            busy       <= next_busy;
            done       <= next_done;
            fail       <= next_fail;
            first_poll <= next_first_poll;
            prdata     <= next_prdata;
            pready     <= next_pready;
        end
    end

    assign pslverr = 1'b0;
endmodule : pfh_top

/* test/pfh_checker.sv */
`timescale 1ns/1ps
// Pin and bus relations that the controller must keep
module pfh_checker (
    input wire logic        clk_i,     // Clock
    input wire logic        reset_n_i, // Reset, low
    input wire logic        psel,      // APB select
    input wire logic        penable,   // APB enable
    input wire logic        pready,    // APB ready
    input wire logic        pslverr,   // APB error
    input wire logic        ce_n_o,    // Chip select
    input wire logic        oe_n_o,    // Output enable
    input wire logic        we_n_o,    // Write strobe
    input wire logic [16:0] addr_o,    // Flash address
    input wire logic [7:0]  dq_o,      // Write byte
    input wire logic        dq_oe_n_o  // Drive enable
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Edges that open and close the write strobe
    sequence s_wr_fall;
        $fell(we_n_o);
    endsequence
    sequence s_wr_rise;
        $rose(we_n_o);
    endsequence
    a_write_pins: assert property (!we_n_o |-> oe_n_o && !ce_n_o)
        else $error("write strobe with bad select or enable");
    a_no_contention: assert property (!oe_n_o |-> dq_oe_n_o && we_n_o)
        else $error("controller drives data during a read");
    a_data_setup: assert property (s_wr_fall |-> !dq_oe_n_o && $stable(dq_o))
        else $error("write byte not ready at strobe fall");
    a_data_hold: assert property (s_wr_rise |-> !dq_oe_n_o && $stable(dq_o))
        else $error("write byte released at strobe rise");
    a_addr_hold: assert property (!ce_n_o && !$past(ce_n_o) |-> $stable(addr_o))
        else $error("address moved while selected");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_no_error: assert property (pready |-> !pslverr)
        else $error("error response given");
endmodule : pfh_checker

/* test/pfh_flash_model.sv */
`timescale 1ns/1ps
// Behavioural byte-wide flash: decoder, sectors, status polling
module pfh_flash_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hA5, // Arbitrary value
    parameter logic [4:0] PROT_SECTOR = 5'h03, // The protected sector
    parameter int         BUSY_READS  = 3      // Status reads before done
) (
    input  wire logic        ce_n_i,  // Chip select
    input  wire logic        oe_n_i,  // Output enable
    input  wire logic        we_n_i,  // Write strobe
    input  wire logic [16:0] addr_i,  // Address
    input  wire logic [7:0]  dq_i,    // Resolved data bus
    output logic [7:0]       dq_o,    // Read data
    output logic             drive_o  // Flash drives data
);
    logic [7:0]  mem [0:131071];
    logic [16:0] la;
    logic [7:0]  last;
    logic        ident, tog, susp, sect;
    int          step, busy;
    wire         wact = !ce_n_i && !we_n_i && oe_n_i;
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
        {ident, tog, susp, sect} = 4'h0;
        step = 0;
        busy = 0;
    end
    assign drive_o = !ce_n_i && !oe_n_i;
    assign dq_o = (busy > 0 && !susp) ? {~last[7], tog, 6'h00}
                : (ident && addr_i[7:0] == 8'h00) ? MAKER_CODE
                : (ident && addr_i[7:0] == 8'h01) ? DEVICE_CODE
                : (ident && addr_i[7:0] == 8'h02) ? {7'h00, addr_i[16:12] == PROT_SECTOR}
                : mem[addr_i];
    // busy counter advanced per status read
    always @(posedge oe_n_i) if (busy > 0 && !susp) begin
        busy--;
        tog = ~tog;
    end
    // address at start of a valid write
    always @(posedge wact) la = addr_i;
    always @(negedge wact) decode(la, dq_i);
    task automatic decode(input logic [16:0] a, input logic [7:0] d);
        logic [4:0] s;
        s = a[16:12];
        // busy flash hears only suspend and resume, and only while sect is set; program leaves sect as the last erase left it
        if (busy > 0) begin
            if (sect && d == 8'hB0) susp = 1'b1;
            if (sect && d == 8'h30) susp = 1'b0;
        end else if (d == 8'hF0) begin
            step = 0;
            ident = 1'b0;
        end else begin
            // wrong step returns to step 0; identification mode, if set, is kept
            case (step)
                0: step = (a == 17'h00555 && d == 8'hAA) ? 1 : 0;
                1: step = (a == 17'h002AA && d == 8'h55) ? 2 : 0;
                2: begin
                    step = (a != 17'h00555) ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
                    if (a == 17'h00555 && d == 8'h90) ident = 1'b1;
                end
                3: begin
                    if (s != PROT_SECTOR) begin
                        mem[a] = mem[a] & d;
                        busy = BUSY_READS;
                    end
                    last = d;
                    step = 0;
                end
                4: step = (a == 17'h00555 && d == 8'hAA) ? 5 : 0;
                5: step = (a == 17'h002AA && d == 8'h55) ? 6 : 0;
                6: begin
                    for (int i = 0; i < 131072; i++)
                        if (i[16:12] != PROT_SECTOR && (d == 8'h10 || i[16:12] == s))
                            mem[i] = 8'hFF;
                    busy = BUSY_READS;
                    sect = (d == 8'h30);
                    last = 8'hFF;
                    step = 0;
                end
                default: step = 0;
            endcase
        end
    endtask : decode
endmodule : pfh_flash_model

/* test/pfh_top_tb.sv */
`timescale 1ns/1ps
module pfh_top_tb;
    import pfh_pkg::*;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
    localparam logic [7:0] DEVID = 8'hA5; // Arbitrary value
    logic        clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        ce_n_o, oe_n_o, we_n_o, dq_oe_n_o, fl_drv;
    logic [16:0] addr_o;
    logic [7:0]  dq_o, fl_dq, dq_i;
    int          num_errors, comparisons;

    pfh_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
        .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dq_i(dq_i));
    pfh_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID), .PROT_SECTOR(5'h03)) u_flash (
        .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(addr_o), .dq_i(dq_i),
        .dq_o(fl_dq), .drive_o(fl_drv));
    // Undriven bus shows the inverse
    assign dq_i = fl_drv ? fl_dq : (!dq_oe_n_o ? dq_o : ~fl_dq);

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // One APB transfer; result lands in rv
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Issue a command and poll busy until it clears; the watchdog ends a hang
    task automatic op(input logic [3:0] c, input logic [16:0] a, input logic [7:0] d);
        apb(1'b1, REG_ADDR, {15'h0, a});
        apb(1'b1, REG_DATA, {24'h0, d});
        apb(1'b1, REG_CMD, {28'h0, c});
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
        end while (rv[ST_BUSY] !== 1'b0);
    endtask : op
    task automatic rd(input logic [16:0] a, input logic [7:0] e);
        op(OP_READ, a, 8'h00);
        apb(1'b0, REG_RDATA, 32'h0);
        chk(rv, {24'h0, e});
    endtask : rd
    task automatic conclude;
        $display("compares %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    // Watchdog
    initial begin
        repeat (90000) @(posedge clk_i);
        num_errors++;
        conclude();
    end
    initial begin
        {reset_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
        num_errors = 0;
        comparisons = 0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, REG_TIMING, 32'h0);
        chk(rv, 32'h0000000A);
        apb(1'b0, REG_POLLCNT, 32'h0);
        chk(rv, 32'h0000FFFF);
        apb(1'b0, 12'h01C, 32'h0);
        chk(rv, 32'h0);
        apb(1'b1, REG_TIMING, 32'h0);
        apb(1'b0, REG_TIMING, 32'h0);
        chk(rv, 32'h00000001);
        apb(1'b1, REG_TIMING, 32'h00000004);
        $display("registers done");
        rd(17'h01234, 8'hFF);
        op(OP_PROGRAM, 17'h01234, 8'h3C);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rv & 32'h7, 32'h2);
        apb(1'b1, REG_STATUS, 32'h6);
        rd(17'h01234, 8'h3C);
        $display("program done");
        op(OP_IDENT, 17'h0, 8'h00);
        rd(17'h00000, MAKER);
        rd(17'h00001, DEVID);
        rd(17'h03002, 8'h01);
        rd(17'h01002, 8'h00);
        op(OP_RESET, 17'h0, 8'h00);
        rd(17'h00000, 8'hFF);
        $display("identification done");
        op(OP_WRITE, 17'h00555, 8'hAA);
        op(OP_WRITE, 17'h00555, 8'h90);
        op(OP_WRITE, 17'h002AA, 8'h55);
        op(OP_WRITE, 17'h00555, 8'h90);
        rd(17'h00000, 8'hFF);
        op(OP_PROGRAM, 17'h03010, 8'h00);
        rd(17'h03010, 8'hFF);
        op(OP_PROGRAM, 17'h02000, 8'h11);
        op(OP_SECTER, 17'h01000, 8'h00);
        rd(17'h01234, 8'hFF);
        rd(17'h02000, 8'h11);
        op(OP_CHIPER, 17'h0, 8'h00);
        rd(17'h02000, 8'hFF);
        $display("erase done");
        apb(1'b1, REG_POLLCNT, 32'h1);
        op(OP_SECTER, 17'h02000, 8'h00);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rv & 32'h4, 32'h4);
        op(OP_SUSPEND, 17'h0, 8'h00);
        rd(17'h04000, 8'hFF);
        op(OP_RESUME, 17'h0, 8'h00);
        $display("poll limit done");
        conclude();
    end
endmodule : pfh_top_tb

bind pfh_top pfh_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
